/* logic/olc_top.sv */
// Mode control for the eight-channel low-side driver
module olc_top
  import olc_pkg::*;
#(
  parameter int OL_CYC = OL_DET_CYC
)
(
  // Clock and analog-supply power-on reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Control pins
  input wire logic ENABLE_IN,
  input wire logic LIMP_HOME_IN,
  input wire logic [3:0] PAR_DRIVE_IN,
  // Supply monitors
  input wire logic DIG_SUPPLY_OK,
  input wire logic SO_DRIVE_OK,
  // Analog fault comparators, one bit per channel
  input wire logic [7:0] OVERLOAD_DET,
  input wire logic [7:0] OVERTEMP_DET,
  input wire logic [7:0] OPEN_LOAD_LOW,
  // Decoded serial command
  input wire logic CMD_VALID,
  input wire logic CMD_FRAME_OK,
  input wire logic [15:0] CMD_DATA,
  // Channel drive and diagnostic current
  output logic [7:0] CHANNEL_OUTPUT,
  output logic [7:0] OL_SINK_EN,
  // Status
  output logic [1:0] DEVICE_MODE,
  output logic TRANSMISSION_ERROR_FLAG,
  output logic [15:0] DIAG_DATA,
  output logic DIAG_VALID,
  output logic [15:0] CMD_REG
);
  // Synchronised pins
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] pin_s;
  logic en_s;
  logic limp_s;
  logic dig_ok_s;
  logic so_ok_s;
  logic [3:0] par_s;
  logic [7:0] ovl_s;
  logic [7:0] ovt_s;
  logic [7:0] olow_s;

  // Mode state and edges
  olc_state_t state_r; // Current device mode
  olc_state_t state_nxt; // Mode for next cycle
  logic en_d_r; // Enable delayed, for the rising edge
  logic en_rise;
  logic leave_limp;
  logic enter_run;

  // Registers
  logic [15:0] cmd_r; // Input register, two bits per channel
  logic [15:0] diag_r; // Output register snapshot
  logic ter_r; // Transmission error flag
  logic pwrup_r; // Power-up global off: no diagnostic current
  logic cmd_take; // Command accepted this cycle
  logic cmd_bad; // Frame rejected this cycle
  logic clr_all; // Clear every fault latch

  // Per-channel request and result vectors
  logic [7:0] want_on;
  logic [7:0] sink_ok;
  logic [7:0] clr_ch;
  logic [7:0] out_v;
  logic [7:0] sink_v;
  logic [15:0] diag_v;

  // Every asynchronous level goes through one shared synchroniser
  assign pin_raw = {DIG_SUPPLY_OK, SO_DRIVE_OK, ENABLE_IN, LIMP_HOME_IN, PAR_DRIVE_IN,
    OVERLOAD_DET, OVERTEMP_DET, OPEN_LOAD_LOW};

  olc_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk(CLK),
    .arst_n(ARST_N),
    .din(pin_raw),
    .dout(pin_s)
  );

  // Split the filtered bundle back into named levels
  assign dig_ok_s = pin_s[31];
  assign so_ok_s = pin_s[30];
  assign en_s = pin_s[29];
  assign limp_s = pin_s[28];
  assign par_s = pin_s[27:24];
  assign ovl_s = pin_s[23:16];
  assign ovt_s = pin_s[15:8];
  assign olow_s = pin_s[7:0];

  // Enable history for edge detection on the filtered level
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      en_d_r <= 1'b0;
    else
      en_d_r <= en_s;
  end

  assign en_rise = en_s && !en_d_r;

  // Mode transitions
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      // Supply lockout: wait for both supplies, limp needs only analog
      ST_LOCK:
      begin
        // limp powers up regardless of enable
        if (limp_s)
          state_nxt = ST_LIMP;
        else if (!dig_ok_s)
          state_nxt = ST_LOCK;
        else if (en_s)
          state_nxt = ST_RUN;
        else
          state_nxt = ST_LOWQ;
      end
      // Low quiescent: sleeping until enable or limp rises
      ST_LOWQ:
      begin
        if (limp_s)
          state_nxt = ST_LIMP;
        else if (!dig_ok_s)
          state_nxt = ST_LOCK;
        else if (en_rise)
          state_nxt = ST_RUN;
      end
      // Normal serial and parallel control
      ST_RUN:
      begin
        if (limp_s)
          state_nxt = ST_LIMP;
        else if (!dig_ok_s)
          state_nxt = ST_LOCK;
        else if (!en_s)
          state_nxt = ST_LOWQ;
      end
      // Limp-home: digital supply monitor deliberately not consulted
      ST_LIMP:
      begin
        if (!limp_s)
          state_nxt = en_s ? ST_RUN : ST_LOWQ;
      end
      default:
        state_nxt = ST_LOCK;
    endcase
  end

  // Mode register; analog supply loss is the asynchronous reset
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      state_r <= ST_LOCK;
    else
      state_r <= state_nxt;
  end

  assign leave_limp = (state_r == ST_LIMP) && (state_nxt != ST_LIMP);
  assign enter_run = (state_r != ST_RUN) && (state_nxt == ST_RUN);

  // commands only accepted in normal mode
  assign cmd_take = CMD_VALID && CMD_FRAME_OK && (state_r == ST_RUN);
  assign cmd_bad = CMD_VALID && !CMD_FRAME_OK && (state_r == ST_RUN);

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      cmd_r <= CMD_RESET;
    // input register returns to reset on limp exit
    else if (leave_limp || state_r == ST_LOCK || state_r == ST_LOWQ)
      cmd_r <= CMD_RESET;
    else if (cmd_take)
      cmd_r <= CMD_DATA;
  end

  // Power-up flag keeps the sink off until the host sends a command
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      pwrup_r <= 1'b1;
    // every entry to global off suppresses the sink
    else if (enter_run)
      pwrup_r <= 1'b1;
    else if (cmd_take)
      pwrup_r <= 1'b0;
  end

  // Transmission error: set events beat the clearing command
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      ter_r <= TER_RESET;
    // limp exit into global off flags an error
    else if (enter_run || cmd_bad)
      ter_r <= 1'b1;
    else if (cmd_take)
      ter_r <= 1'b0;
  end

  assign clr_all = leave_limp || (state_r == ST_LOCK) || (state_r == ST_LOWQ);

  // Per-channel drive request, sink permission and clear
  always_comb
  begin
    want_on = 8'h00;
    sink_ok = 8'h00;
    clr_ch = 8'h00;
    for (int i = 0; i < NUM_CH; i++)
    begin
      clr_ch[i] = clr_all;
      if (state_r == ST_RUN)
      begin
        case (cmd_r[2*i +: 2])
          CMD_STANDBY:
            clr_ch[i] = 1'b1;
          // pair input k to channels k and k+4
          CMD_INPUT:
          begin
            want_on[i] = par_s[i % NUM_IN];
            sink_ok[i] = 1'b1;
          end
          CMD_ON:
          begin
            want_on[i] = 1'b1;
            sink_ok[i] = 1'b1;
          end
          CMD_OFF:
            sink_ok[i] = !pwrup_r;
          default:
            want_on[i] = 1'b0;
        endcase
      end
      // limp drives the lower four, upper held off
      else if (state_r == ST_LIMP && i < NUM_IN)
        want_on[i] = par_s[i];
    end
  end

  // Channel slices; faults latch in normal and limp modes so limp keeps protection
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      olc_chan_if cif ();
      assign cif.want_on = want_on[g];
      assign cif.sink_ok = sink_ok[g];
      // latched faults need the clear path
      assign cif.clr = clr_ch[g];
      assign cif.ovl_det = ovl_s[g];
      assign cif.ovt_det = ovt_s[g];
      assign cif.open_low = olow_s[g];
      assign out_v[g] = cif.out;
      assign sink_v[g] = cif.sink;
      assign diag_v[2*g +: 2] = cif.diag;
      olc_chan #(
        .OL_CYC(OL_CYC)
      ) u_chan (
        .clk(CLK),
        .arst_n(ARST_N),
        .ch(cif.chan)
      );
    end
  endgenerate

  // snapshot frozen while serial drive is down
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      diag_r <= DIAG_RESET;
    else if (so_ok_s)
      diag_r <= diag_v;
  end

  // Outputs: channel drive and sink come straight from slice flops
  assign CHANNEL_OUTPUT = out_v;
  assign OL_SINK_EN = sink_v;
  assign DEVICE_MODE = state_r;
  assign TRANSMISSION_ERROR_FLAG = ter_r;
  assign DIAG_DATA = diag_r;
  assign DIAG_VALID = so_ok_s;
  assign CMD_REG = cmd_r;

  // Checks on the mode controller
  property p_limp_upper;
    @(posedge CLK) disable iff (!ARST_N)
      (state_r == ST_LIMP) && ($past(state_r) == ST_LIMP) |-> (CHANNEL_OUTPUT[7:4] == 4'h0);
  endproperty
  a_limp_upper: assert property (p_limp_upper) else $error("upper outputs on in limp");

  property p_limp_ignore;
    @(posedge CLK) disable iff (!ARST_N)
      (state_r == ST_LIMP) && CMD_VALID && !leave_limp |=> (cmd_r == $past(cmd_r));
  endproperty
  a_limp_ignore: assert property (p_limp_ignore) else $error("command taken in limp");

  property p_limp_exit;
    @(posedge CLK) disable iff (!ARST_N)
      leave_limp |=> (cmd_r == CMD_RESET) ##1 (OL_SINK_EN == 8'h00);
  endproperty
  a_limp_exit: assert property (p_limp_exit) else $error("limp exit not reset");

  property p_ter_limp;
    @(posedge CLK) disable iff (!ARST_N)
      leave_limp && en_s |=> TRANSMISSION_ERROR_FLAG && (state_r == ST_RUN);
  endproperty
  a_ter_limp: assert property (p_ter_limp) else $error("flag not set on limp exit");

  property p_en_wake;
    @(posedge CLK) disable iff (!ARST_N)
      (state_r == ST_LOWQ) && en_rise && !limp_s && dig_ok_s |=> (state_r == ST_RUN);
  endproperty
  a_en_wake: assert property (p_en_wake) else $error("enable did not wake");

  property p_lock_off;
    @(posedge CLK) disable iff (!ARST_N)
      (state_r == ST_LOCK) [*2] |-> (CHANNEL_OUTPUT == 8'h00);
  endproperty
  a_lock_off: assert property (p_lock_off) else $error("output on in lockout");

  property p_off_cmd;
    @(posedge CLK) disable iff (!ARST_N)
      ((state_r == ST_RUN) && (cmd_r[1:0] == CMD_OFF)) [*2] |-> !CHANNEL_OUTPUT[0];
  endproperty
  a_off_cmd: assert property (p_off_cmd) else $error("off channel driven");

  property p_pwrup_sink;
    @(posedge CLK) disable iff (!ARST_N)
      enter_run |=> ##1 (OL_SINK_EN == 8'h00);
  endproperty
  a_pwrup_sink: assert property (p_pwrup_sink) else $error("sink on at power-up");

  c_limp: cover property (@(posedge CLK) disable iff (!ARST_N) leave_limp);
  c_wake: cover property (@(posedge CLK) disable iff (!ARST_N) en_rise && state_r == ST_LOWQ);
  c_cmd: cover property (@(posedge CLK) disable iff (!ARST_N) cmd_take);
endmodule : olc_top

/* logic/olc_pkg.sv */
// Constants and types shared by the octal low-side mode control block
//
// Behaviour
// - input mode pairs input k to outputs k, k+4
// - channel commanded off ignores its paired input
// - faults under parallel control stay latched until cleared
// - limp-home drives outputs 1-4 from inputs, 5-8 off
// - limp-home keeps overload, over-temperature detection and reporting
// - limp-home ignores commands; restart needs limp toggle
// - leaving limp-home resets registers, no diagnostic current
// - analog supply loss locks out; digital loss ignored in limp
// - faults kept while serial output cannot drive
// - limp-home to global off sets transmission error
// - enable rising leaves low quiescent into global off
// - power-up is enable or limp-home; limp wins
// - over-temperature latches only its own channel off
// - sink current only while off; switching unaffected
// - open load flagged only when low under sink
// - power-up into global off without diagnostic current
// - input register for modes, output register for diagnostics
// - fault clears: standby channel, resets, enable low, limp exit
// - two-bit command: standby, input, on, off
// - overload turns channel off and latches it off
package olc_pkg;
  // Channel and input counts
  localparam int NUM_CH = 8;
  localparam int NUM_IN = 4;
  // Two-bit channel commands
  localparam logic [1:0] CMD_STANDBY = 2'h0;
  localparam logic [1:0] CMD_INPUT = 2'h1;
  localparam logic [1:0] CMD_ON = 2'h2;
  localparam logic [1:0] CMD_OFF = 2'h3;
  // Input register value after any reset: every channel OFF
  localparam logic [15:0] CMD_RESET = 16'hFFFF;
  // Two-bit diagnostic codes per channel
  localparam logic [1:0] DIAG_NONE = 2'h0;
  localparam logic [1:0] DIAG_OPEN = 2'h1;
  localparam logic [1:0] DIAG_OVL = 2'h2;
  localparam logic [1:0] DIAG_OVT = 2'h3;
  // Output register and flag reset values
  localparam logic [15:0] DIAG_RESET = 16'h0000;
  localparam logic TER_RESET = 1'b1;
  // Clock rate and open-load detection time
  localparam int CLK_MHZ = 200;
  localparam int OL_DET_US = 200;
  localparam int OL_DET_CYC = OL_DET_US * CLK_MHZ;
  // Width of the pin bundle through the synchroniser
  localparam int SYNC_W = 32;
  // Device modes
  typedef enum logic [1:0] {
    ST_LOCK = 2'h0,
    ST_LOWQ = 2'h1,
    ST_RUN = 2'h2,
    ST_LIMP = 2'h3
  } olc_state_t;
endpackage : olc_pkg

/* logic/olc_chan_if.sv */
// Link between mode control and one channel slice
interface olc_chan_if;
  logic want_on;
  logic sink_ok;
  logic clr;
  logic ovl_det;
  logic ovt_det;
  logic open_low;
  logic out;
  logic sink;
  logic [1:0] diag;
  modport ctrl (output want_on, sink_ok, clr, ovl_det, ovt_det, open_low,
    input out, sink, diag);
  modport chan (input want_on, sink_ok, clr, ovl_det, ovt_det, open_low,
    output out, sink, diag);
endinterface : olc_chan_if

/* logic/olc_sync.sv */
// Three-stage pin synchroniser with agreement filter
module olc_sync
  import olc_pkg::*;
#(
  parameter int W = SYNC_W
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Raw pins and filtered result
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_r; // Metastable stage, read only by s2_r
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      dout <= '0;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // A bit changes only once two stable stages agree
      dout <= (s2_r & s3_r) | (dout & (s2_r | s3_r));
    end
  end
endmodule : olc_sync

/* logic/olc_chan.sv */
// One channel slice: fault latches, drive, open-load sink
module olc_chan
  import olc_pkg::*;
#(
  parameter int OL_CYC = OL_DET_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Link to mode control
  olc_chan_if.chan ch
);
  logic ovl_r; // Overload latch
  logic ovt_r; // Over-temperature latch
  logic open_r; // Open-load record
  logic out_r; // Driver gate
  logic sink_r; // Diagnostic sink current on
  logic [15:0] cnt_r; // Time with sink applied
  logic ol_done;

  assign ol_done = (cnt_r == 16'(OL_CYC - 1));

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ovl_r <= 1'b0;
    else if (ch.ovl_det && out_r)
      ovl_r <= 1'b1;
    else if (ch.clr)
      ovl_r <= 1'b0;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ovt_r <= 1'b0;
    else if (ch.ovt_det)
      ovt_r <= 1'b1;
    else if (ch.clr)
      ovt_r <= 1'b0;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      out_r <= 1'b0;
    else
      out_r <= ch.want_on && !ovl_r && !ovt_r;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      sink_r <= 1'b0;
    else
      sink_r <= ch.sink_ok && !ch.want_on && !out_r;
  end

  // Detection timer restarts whenever the sink drops
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_r <= 16'h0000;
    else if (!sink_r)
      cnt_r <= 16'h0000;
    else if (!ol_done)
      cnt_r <= cnt_r + 16'h0001;
  end

  // flag only low level under sink
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      open_r <= 1'b0;
    else if (sink_r && ol_done && ch.open_low)
      open_r <= 1'b1;
    else if (ch.clr)
      open_r <= 1'b0;
  end

  assign ch.out = out_r;
  assign ch.sink = sink_r;
  // Thermal reported first, then overload, then open load
  assign ch.diag = ovt_r ? DIAG_OVT : ovl_r ? DIAG_OVL : open_r ? DIAG_OPEN : DIAG_NONE;

  property p_sink_off;
    @(posedge clk) disable iff (!arst_n) sink_r |-> !out_r;
  endproperty
  a_sink_off: assert property (p_sink_off) else $error("sink on with driver on");

  property p_ovl_latch;
    @(posedge clk) disable iff (!arst_n) (ch.ovl_det && out_r) |=> ##1 !out_r;
  endproperty
  a_ovl_latch: assert property (p_ovl_latch) else $error("overload not latched off");

  property p_open_cause;
    @(posedge clk) disable iff (!arst_n)
      $rose(open_r) |-> $past(sink_r) && $past(ch.open_low) && $past(ol_done);
  endproperty
  a_open_cause: assert property (p_open_cause) else $error("open load without cause");

  c_open_seen: cover property (@(posedge clk) disable iff (!arst_n) $rose(open_r));
endmodule : olc_chan

/* testbench/olc_host_model.sv */
// Host model: decoded serial command frames and the parallel drive pins
module olc_host_model
  import olc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Decoded command frame
  output logic cmd_valid,
  output logic cmd_frame_ok,
  output logic [15:0] cmd_data,
  // Parallel drive pins
  output logic [3:0] par_drive
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet bus at time zero
  initial
  begin
    cmd_valid = 1'b0;
    cmd_frame_ok = 1'b0;
    cmd_data = 16'h0000;
    par_drive = 4'h0;
  end

  // two-bit channel commands
  // One-cycle frame; data is inverted afterwards so no stale word lingers
  task automatic send_cmd(input logic [15:0] d, input logic ok);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_frame_ok <= ok;
    cmd_data <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_frame_ok <= ~ok;
    cmd_data <= ~d;
  endtask : send_cmd

  // New level on the parallel pins
  task automatic set_par(input logic [3:0] p);
    @(posedge clk);
    par_drive <= p;
  endtask : set_par

  // long low phase
  // Inputs stay low past turn-off plus detection time, else open load is missed
  task automatic hold_low(input int cyc);
    @(posedge clk);
    par_drive <= 4'h0;
    repeat (cyc) @(posedge clk);
  endtask : hold_low
endmodule : olc_host_model

/* testbench/olc_top_tb_top.sv */
// Self-checking bench for the octal low-side mode control block
`define CHECK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module olc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import olc_pkg::*;
  // Short detection count keeps the run brief
  localparam int OL_SIM = 20;
  // Table row: command, pin levels, expected drive
  typedef struct packed {logic [15:0] cmd; logic [3:0] par; logic [7:0] out;} olc_row_t;
  olc_row_t rows [6] = '{
    '{16'hAAAA, 4'h0, 8'hFF},
    '{16'h5555, 4'h5, 8'h55},
    '{16'h5555, 4'hA, 8'hAA},
    '{16'h5755, 4'hF, 8'hEF},
    '{16'h0000, 4'hF, 8'h00},
    '{16'hFFFF, 4'hF, 8'h00}
  };
  // Stimulus and observed signals
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic enable = 1'b1;
  logic limp = 1'b0;
  logic dig_ok = 1'b1;
  logic so_ok = 1'b1;
  logic [7:0] ovl = 8'h00;
  logic [7:0] ovt = 8'h00;
  logic [7:0] ol_low = 8'h00;
  logic cmd_valid;
  logic cmd_ok;
  logic [15:0] cmd_data;
  logic [3:0] par;
  logic [7:0] ch_out;
  logic [7:0] sink;
  logic [1:0] mode;
  logic transmission_error_flag;
  logic [15:0] diag;
  logic diag_valid;
  logic [15:0] cmd_reg;
  // Score counters
  int err_count = 0;
  int tests_run = 0;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // Far side: host driving frames and pins
  olc_host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd_frame_ok(cmd_ok),
    .cmd_data(cmd_data), .par_drive(par));

  // Block under test
  olc_top #(.OL_CYC(OL_SIM)) uut (.CLK(clk), .ARST_N(arst_n), .ENABLE_IN(enable),
    .LIMP_HOME_IN(limp), .PAR_DRIVE_IN(par), .DIG_SUPPLY_OK(dig_ok), .SO_DRIVE_OK(so_ok),
    .OVERLOAD_DET(ovl), .OVERTEMP_DET(ovt), .OPEN_LOAD_LOW(ol_low), .CMD_VALID(cmd_valid),
    .CMD_FRAME_OK(cmd_ok), .CMD_DATA(cmd_data), .CHANNEL_OUTPUT(ch_out), .OL_SINK_EN(sink),
    .DEVICE_MODE(mode), .TRANSMISSION_ERROR_FLAG(transmission_error_flag), .DIAG_DATA(diag),
    .DIAG_VALID(diag_valid), .CMD_REG(cmd_reg));

  // Let synchroniser and drive pipeline land, then sample mid-cycle
  task automatic settle;
    repeat (12) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // Verdict and end of run
  task automatic stop_test;
    if (err_count == 0 && tests_run > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  // Watchdog far beyond the well under a thousand cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    settle();
    settle();
    // Power-up state: global off, no sink current
    `CHECK(mode, ST_RUN)
    `CHECK(transmission_error_flag, TER_RESET)
    `CHECK(cmd_reg, CMD_RESET)
    `CHECK(sink, 8'h00)
    `CHECK(ch_out, 8'h00)
    // Table of plain commands and pin levels
    foreach (rows[i])
    begin
      host.set_par(rows[i].par);
      host.send_cmd(rows[i].cmd, 1'b1);
      settle();
      `CHECK(ch_out, rows[i].out)
      `CHECK(cmd_reg, rows[i].cmd)
      `CHECK(transmission_error_flag, 1'b0)
    end
    // Bad frame length: flag set, register kept
    host.send_cmd(16'h0000, 1'b0);
    settle();
    `CHECK(transmission_error_flag, 1'b1)
    `CHECK(cmd_reg, 16'hFFFF)
    // Overload on ch2, overtemp on ch5 under parallel control
    host.send_cmd(16'h5555, 1'b1);
    ovl <= 8'h04;
    ovt <= 8'h20;
    settle();
    @(posedge clk);
    ovl <= 8'h00;
    ovt <= 8'h00;
    settle();
    `CHECK(ch_out, 8'hDB)
    `CHECK(diag, 16'h0C20)
    // Same command again does not restart latched channels
    host.send_cmd(16'h5555, 1'b1);
    settle();
    `CHECK(ch_out, 8'hDB)
    // Standby on the two faulted channels clears them only
    host.send_cmd(16'h5145, 1'b1);
    settle();
    `CHECK(diag, 16'h0000)
    host.send_cmd(16'h5555, 1'b1);
    settle();
    `CHECK(ch_out, 8'hFF)
    // Open load on ch0 only, seen during a long low phase
    @(posedge clk);
    ol_low <= 8'h01;
    host.hold_low(OL_SIM * 3);
    @(negedge clk);
    `CHECK(sink, 8'hFF)
    `CHECK(diag, 16'h0001)
    host.set_par(4'h1);
    settle();
    `CHECK(ch_out, 8'h11)
    `CHECK(sink, 8'hEE)
    @(posedge clk);
    ol_low <= 8'h00;
    // Limp-home entry with enable as don't-care
    limp <= 1'b1;
    host.set_par(4'h9);
    settle();
    settle();
    `CHECK(mode, ST_LIMP)
    `CHECK(ch_out, 8'h09)
    host.send_cmd(16'hAAAA, 1'b1);
    dig_ok <= 1'b0;
    settle();
    `CHECK(cmd_reg, 16'h5555)
    `CHECK(mode, ST_LIMP)
    // Overload still latches during limp-home
    @(posedge clk);
    ovl <= 8'h01;
    settle();
    @(posedge clk);
    ovl <= 8'h00;
    settle();
    `CHECK(ch_out, 8'h08)
    `CHECK(diag[1:0], DIAG_OVL)
    // Serial output drive lost: snapshot frozen while a new fault latches
    @(posedge clk);
    so_ok <= 1'b0;
    settle();
    @(posedge clk);
    ovt <= 8'h02;
    settle();
    `CHECK(diag_valid, 1'b0)
    `CHECK(diag[3:2], DIAG_NONE)
    @(posedge clk);
    ovt <= 8'h00;
    so_ok <= 1'b1;
    dig_ok <= 1'b1;
    settle();
    `CHECK(diag[1:0], DIAG_OVL)
    `CHECK(diag[3:2], DIAG_OVT)
    // Leave limp-home with enable high
    @(posedge clk);
    limp <= 1'b0;
    settle();
    settle();
    `CHECK(mode, ST_RUN)
    `CHECK(transmission_error_flag, 1'b1)
    `CHECK(cmd_reg, CMD_RESET)
    `CHECK(diag, DIAG_RESET)
    `CHECK(sink, 8'h00)
    // Leave limp-home with enable low, then wake by enable edge
    @(posedge clk);
    limp <= 1'b1;
    enable <= 1'b0;
    settle();
    settle();
    @(posedge clk);
    limp <= 1'b0;
    settle();
    settle();
    `CHECK(mode, ST_LOWQ)
    @(posedge clk);
    enable <= 1'b1;
    settle();
    settle();
    `CHECK(mode, ST_RUN)
    `CHECK(transmission_error_flag, 1'b1)
    // Digital supply loss in normal mode locks out until it returns
    @(posedge clk);
    dig_ok <= 1'b0;
    settle();
    `CHECK(mode, ST_LOCK)
    @(posedge clk);
    dig_ok <= 1'b1;
    settle();
    `CHECK(mode, ST_RUN)
    // Analog-supply loss in mid-run drops every output
    host.send_cmd(16'hAAAA, 1'b1);
    settle();
    `CHECK(ch_out, 8'hFF)
    @(posedge clk);
    arst_n <= 1'b0;
    @(negedge clk);
    `CHECK(ch_out, 8'h00)
    `CHECK(mode, ST_LOCK)
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    // Two edges after the second release the pins are still in flight
    @(negedge clk);
    @(negedge clk);
    `CHECK(ch_out, 8'h00)
    `CHECK(mode, ST_LOCK)
    settle();
    `CHECK(mode, ST_RUN)
    `CHECK(transmission_error_flag, TER_RESET)
    `CHECK(cmd_reg, CMD_RESET)
    `CHECK(sink, 8'h00)
    stop_test();
  end
endmodule : olc_top_tb_top
